// ==== bench/epl_core_asserts.sv ====
`timescale 1ns/1ps
// ****
// port checker
// ****
module epl_core_chk (
   // clock and reset
   input wire ref_clk,
   input wire reset,
   // management port
   input wire [4:0] mgmt_reg_address,
   input wire mgmt_wr,
   input wire [15:0] mgmt_wr_data,
   input wire mgmt_rd,
   input wire [15:0] mgmt_rd_data_ff,
   input wire mgmt_rd_valid_ff,
   // controller and line side
   input wire [7:0] sfr_rd_data_ff,
   input wire mac_tx_request,
   input wire full_duplex,
   input wire phy_tx_enable,
   input wire eth_global_irq_enable,
   input wire eth_master_irq_clear,
   input wire eth_master_irq_flag_ff
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (reset);
   sequence s_stat_rd;
      mgmt_rd && mgmt_reg_address == 5'h11;
   endsequence
   a_rd_valid_pulse: assert property (mgmt_rd |=> mgmt_rd_valid_ff) else $error("read valid missing");
   a_stat_tx_bit: assert property (s_stat_rd |=> mgmt_rd_data_ff[13] == $past(mac_tx_request && phy_tx_enable))
      else $error("transmit status wrong");
   a_stat_link_bit: assert property (s_stat_rd |=> mgmt_rd_data_ff[10] == $past(phy_tx_enable))
      else $error("link status wrong");
   // collision only in half duplex, needs both directions
   a_stat_col_bit: assert property (s_stat_rd |=> mgmt_rd_data_ff[11] ==
      (mgmt_rd_data_ff[13] && mgmt_rd_data_ff[12] && !$past(full_duplex))) else $error("collision status wrong");
   a_stat_unused_zero: assert property (s_stat_rd |=> (mgmt_rd_data_ff & 16'hc3ff) == 16'h0000)
      else $error("status unused bits set");
   a_flag_gaps_zero: assert property (sfr_rd_data_ff[7] == 1'b0 && sfr_rd_data_ff[2] == 1'b0)
      else $error("unimplemented controller bit set");
   a_force_link_tx: assert property (mgmt_wr && mgmt_reg_address == 5'h10 && mgmt_wr_data[14] |=> phy_tx_enable)
      else $error("forced link does not allow transmit");
   a_master_needs_global: assert property ($rose(eth_master_irq_flag_ff) |-> $past(eth_global_irq_enable))
      else $error("master flag set without global enable");
   a_master_flag_sticky: assert property (eth_master_irq_flag_ff && !eth_master_irq_clear |=> eth_master_irq_flag_ff)
      else $error("master flag dropped without clear");
   c_stat_read: cover property (s_stat_rd ##1 mgmt_rd_valid_ff);
   c_master_set: cover property ($rose(eth_master_irq_flag_ff));
   c_master_clr: cover property ($fell(eth_master_irq_flag_ff));
endmodule // epl_core_chk

bind epl_core epl_core_chk i_chk (.ref_clk, .reset, .mgmt_reg_address, .mgmt_wr, .mgmt_wr_data, .mgmt_rd,
   .mgmt_rd_data_ff, .mgmt_rd_valid_ff, .sfr_rd_data_ff, .mac_tx_request, .full_duplex, .phy_tx_enable,
   .eth_global_irq_enable, .eth_master_irq_clear, .eth_master_irq_flag_ff);

// ==== bench/epl_link_partner.sv ====
`timescale 1ns/1ps
// ****
// far-end link partner
// ****
module epl_link_partner (
   // commands from the bench
   input wire attach,
   input wire talk,
   // line pins
   output wire partner_detect_pin,
   output wire rx_carrier_pin
);
   // pins move off the clock edge, so the synchronisers see truly async levels
   assign #7 partner_detect_pin = attach;
   // no carrier without a cable
   assign #7 rx_carrier_pin = attach & talk;
endmodule // epl_link_partner

// ==== bench/tb_eth_phy_led_status_irq_enable.sv ====
`timescale 1ns/1ps
// ****
// bench
// ****
module tb_eth_phy_led_status_irq_enable;
   logic ref_clk = 0, reset = 1, mw = 0, mr = 0, sa = 0, sw = 0, tq = 0, fd = 0, pkt = 0, glob = 0, mclr = 0;
   logic att = 0, talk = 0;
   logic [4:0] ma = 0;
   logic [15:0] md = 0;
   logic [7:0] sd = 0;
   logic [3:0] ev = 0;
   logic [31:0] rnd = 32'h1627;
   logic [7:0] fb [4] = '{8'h01, 8'h02, 8'h08, 8'h20};
   wire [15:0] mq;
   wire [7:0] sq;
   wire det, rxc, mv, tx_en, hdl, rxn, mflag, led_a, led_b;
   int n_mismatch = 0, n_compared = 0, cnt;
   initial forever #20 ref_clk = ~ref_clk;
   // short ticks keep stretch spans a few dozen cycles; slow blink stays at its default, it is not timed here
   epl_core #(.TICK_CYCLES(4), .NORMAL_MS(2), .MEDIUM_MS(4), .LONG_MS(8), .FAST_MS(4)) i_dut (
      .ref_clk(ref_clk), .reset(reset), .mgmt_reg_address(ma), .mgmt_wr(mw), .mgmt_wr_data(md), .mgmt_rd(mr),
      .mgmt_rd_data_ff(mq), .mgmt_rd_valid_ff(mv), .sfr_addr(sa), .sfr_wr(sw), .sfr_wr_data(sd),
      .sfr_rd_data_ff(sq), .mac_tx_request(tq), .partner_detect_pin(det), .rx_carrier_pin(rxc), .full_duplex(fd),
      .phy_tx_enable(tx_en), .half_duplex_loopback_off(hdl), .receive_normal_mode(rxn), .packet_pending(pkt),
      .copy_done_event(ev[3]), .transmit_done_event(ev[2]), .transmit_error_event(ev[1]),
      .receive_error_event(ev[0]), .eth_global_irq_enable(glob), .eth_master_irq_clear(mclr),
      .eth_master_irq_flag_ff(mflag), .led_a_on(led_a), .led_b_on(led_b));
   epl_link_partner i_partner (.attach(att), .talk(talk), .partner_detect_pin(det), .rx_carrier_pin(rxc));
   // ****
   // tasks and models
   // ****
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic mwr(input logic [4:0] a, input logic [15:0] v);
      @(posedge ref_clk);
      ma <= a;
      md <= v;
      mw <= 1'b1;
      @(posedge ref_clk);
      mw <= 1'b0;
   endtask
   task automatic mrd(input logic [4:0] a, input logic [15:0] e, input string nm);
      @(posedge ref_clk);
      ma <= a;
      mr <= 1'b1;
      @(posedge ref_clk);
      mr <= 1'b0;
      #1 chk(nm, mq, e);
   endtask
   task automatic swr(input logic a, input logic [7:0] v);
      @(posedge ref_clk);
      sa <= a;
      sd <= v;
      sw <= 1'b1;
      @(posedge ref_clk);
      sw <= 1'b0;
   endtask
   task automatic srd(input logic a, input logic [7:0] e, input string nm);
      @(posedge ref_clk);
      sa <= a;
      cyc(2);
      #1 chk(nm, sq, e);
   endtask
   task automatic pulse_ev(input int k);
      @(posedge ref_clk);
      ev <= 4'h1 << k;
      @(posedge ref_clk);
      ev <= 4'h0;
   endtask
   function automatic logic led_exp(input logic [3:0] c, input logic tx, rx, lk, dx);
      case (c)
         4'h1: return tx;
         4'h2: return rx;
         4'h3: return tx & rx & !dx;
         4'h4: return lk;
         4'h5: return dx;
         4'h7: return tx | rx;
         4'h8: return 1'b1;
         4'hc: return lk & !rx;
         4'hd: return lk & !(tx | rx);
         default: return 1'b0;
      endcase
   endfunction
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic wrap_up;
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      cyc(20000);
      n_mismatch++;
      wrap_up;
   end
   // ****
   // scenarios
   // ****
   initial begin
      cyc(5);
      reset <= 1'b0;
      mrd(5'h14, 16'h3422, "led_ctl_rst");
      mrd(5'h10, 16'h0000, "ctl2_rst");
      mrd(5'h05, 16'h0000, "unmapped");
      mwr(5'h10, 16'hffff);
      mrd(5'h10, 16'h4110, "ctl2_wr");
      chk("ops_bits", {hdl, rxn}, 2'b11);
      // forced, attached half and full duplex, down, forced without partner
      for (int i = 0; i < 4; i++) begin
         mwr(5'h10, {1'b0, i != 2, 14'h0110});
         att <= i < 2;
         talk <= 1'b1;
         tq <= 1'b1;
         fd <= i[0];
         cyc(4);
         mrd(5'h11, {2'b00, i != 2, i < 2, i == 0, i != 2, 10'h000}, "status");
         chk("tx_en", tx_en, i != 2);
      end
      mwr(5'h10, 16'h0110);
      // blink codes skipped: their phase is free-running
      for (int c = 0; c < 16; c++) begin
         if (c == 10 || c == 11) continue;
         rnd = lfsr(rnd);
         att <= rnd[0];
         talk <= rnd[1];
         tq <= rnd[2];
         fd <= rnd[3];
         mwr(5'h14, {4'h3, c[3:0], c[3:0] ^ 4'h1, 2'b10, rnd[4], 1'b0});
         cyc(60);
         chk("led_a", led_a, led_exp(c[3:0], rnd[2] & rnd[0], rnd[0] & rnd[1], rnd[0], rnd[3]));
         chk("led_b", led_b, led_exp(c[3:0] ^ 4'h1, rnd[2] & rnd[0], rnd[0] & rnd[1], rnd[0], rnd[3]));
      end
      att <= 1'b1;
      for (int f = 0; f < 4; f++) begin
         talk <= 1'b1;
         mwr(5'h14, {12'h329, f == 3 ? 2'b00 : f[1:0], f != 3, 1'b0});
         cyc(20);
         talk <= 1'b0;
         cnt = 0;
         #1;
         while (led_a === 1'b1 && cnt < 100) begin
            #40;
            cnt++;
         end
         if (f == 3)
            chk("lit_plain", cnt <= 5, 1'b1);
         else
            chk("lit_stretch", cnt >= (8 << f) - 4 && cnt <= (8 << f) + 12, 1'b1);
      end
      swr(1'b0, 8'hff);
      srd(1'b0, 8'h7b, "en_mask");
      swr(1'b0, 8'h00);
      glob <= 1'b1;
      for (int k = 0; k < 4; k++) begin
         pulse_ev(k);
         srd(1'b1, fb[k], "flag_set");
         chk("mflag_off", mflag, 1'b0);
         swr(1'b1, fb[k]);
         srd(1'b1, 8'h00, "flag_clr");
      end
      swr(1'b0, 8'h08);
      pulse_ev(2);
      cyc(3);
      #1 chk("mflag_on", mflag, 1'b1);
      swr(1'b1, 8'h08);
      @(posedge ref_clk);
      mclr <= 1'b1;
      pkt <= 1'b1;
      @(posedge ref_clk);
      mclr <= 1'b0;
      srd(1'b1, 8'h40, "pkt_flag");
      chk("mflag_clr", mflag, 1'b0);
      pkt <= 1'b0;
      // partner has come and gone during the status and led code runs, enables still off
      mrd(5'h13, 16'h0010, "phy_flag_plain");
      srd(1'b1, 8'h00, "link_gated");
      mwr(5'h12, 16'h0012);
      swr(1'b0, 8'h10);
      att <= 1'b0;
      cyc(6);
      srd(1'b1, 8'h10, "link_flag");
      chk("mflag_link", mflag, 1'b1);
      mrd(5'h13, 16'h0014, "phy_flag_en");
      srd(1'b1, 8'h00, "link_clr");
      mrd(5'h13, 16'h0000, "phy_flag_rd");
      wrap_up;
   end
endmodule // tb_eth_phy_led_status_irq_enable

// ==== design/epl_core.v ====
`timescale 1ns/1ps
`include "epl_consts.vh"

module epl_core #(
   parameter TICK_CYCLES = `EPL_CLK_KHZ * `EPL_TICK_MS,
   parameter CNT_W = 9,
   parameter NORMAL_MS = `EPL_NORMAL_MS,
   parameter MEDIUM_MS = `EPL_MEDIUM_MS,
   parameter LONG_MS = `EPL_LONG_MS,
   parameter FAST_MS = `EPL_FAST_MS,
   parameter SLOW_MS = `EPL_SLOW_MS
) (
   // clock and reset
   input wire ref_clk,
   input wire reset,
   // phy management port
   input wire [4:0] mgmt_reg_address,
   input wire mgmt_wr,
   input wire [15:0] mgmt_wr_data,
   input wire mgmt_rd,
   output reg [15:0] mgmt_rd_data_ff,
   output reg mgmt_rd_valid_ff,
   // controller register port
   input wire sfr_addr,
   input wire sfr_wr,
   input wire [7:0] sfr_wr_data,
   output reg [7:0] sfr_rd_data_ff,
   // line side
   input wire mac_tx_request,
   input wire partner_detect_pin,
   input wire rx_carrier_pin,
   input wire full_duplex,
   output wire phy_tx_enable,
   output wire half_duplex_loopback_off,
   output wire receive_normal_mode,
   // module events
   input wire packet_pending,
   input wire copy_done_event,
   input wire transmit_done_event,
   input wire transmit_error_event,
   input wire receive_error_event,
   // controller interrupt
   input wire eth_global_irq_enable,
   input wire eth_master_irq_clear,
   output reg eth_master_irq_flag_ff,
   // leds
   output wire led_a_on,
   output wire led_b_on
);

   localparam [19:0] TICK_LAST = TICK_CYCLES[19:0] - 20'h0_0001;
   localparam [CNT_W-1:0] NORMAL_LEN = NORMAL_MS[CNT_W-1:0];
   localparam [CNT_W-1:0] MEDIUM_LEN = MEDIUM_MS[CNT_W-1:0];
   localparam [CNT_W-1:0] LONG_LEN = LONG_MS[CNT_W-1:0];
   localparam [CNT_W-1:0] FAST_LAST = FAST_MS[CNT_W-1:0] - {{(CNT_W-1){1'b0}}, 1'b1};
   localparam [CNT_W-1:0] SLOW_LAST = SLOW_MS[CNT_W-1:0] - {{(CNT_W-1){1'b0}}, 1'b1};
   localparam [15:0] RST_CTL2 = `EPL_RST_CTL2, RST_LED_CTL = `EPL_RST_LED_CTL;

   // wrap-around ms counter step
   function [CNT_W-1:0] ms_step;
      input [CNT_W-1:0] cnt;
      input [CNT_W-1:0] last;
      begin
         ms_step = (cnt == last) ? {CNT_W{1'b0}} : cnt + {{(CNT_W-1){1'b0}}, 1'b1};
      end
   endfunction

   reg [1:0] partner_sync_ff, carrier_sync_ff;
   reg link_prev_ff, force_link_up_ff, hdl_off_ff, rx_normal_ff;
   reg [13:1] led_ctrl_ff;
   reg phy_link_irq_en_ff, phy_global_irq_en_ff, phy_link_flag_ff, phy_global_flag_ff;
   reg [7:0] eth_irq_en_ff;
   reg copy_done_flag_ff, tx_done_flag_ff, tx_err_flag_ff, rx_err_flag_ff, link_change_flag_ff;
   reg [19:0] tick_cnt_ff;
   reg [CNT_W-1:0] fast_cnt_ff, slow_cnt_ff, hold_len;
   reg blink_fast_ff, blink_slow_ff;
   reg [15:0] nxt_rd_data;

   wire live_link_up, phy_tx_active, phy_rx_active, phy_collision_active;
   wire link_evt, phy_link_irq, phy_flag_rd, flag_clr_wr, ms_tick;
   wire tx_long, rx_long, col_long;
   wire [7:0] flag_val;

   // ****************************************
   // pin synchronisers
   // ****************************************
   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         partner_sync_ff <= 2'h0;
         carrier_sync_ff <= 2'h0;
      end else begin
         partner_sync_ff <= {partner_sync_ff[0], partner_detect_pin};
         carrier_sync_ff <= {carrier_sync_ff[0], rx_carrier_pin};
      end
   end

   // ****************************************
   // line status
   // ****************************************
   // force reports link up
   assign live_link_up = force_link_up_ff | partner_sync_ff[1];
   assign phy_tx_enable = live_link_up;
   assign phy_tx_active = mac_tx_request & live_link_up;
   assign phy_rx_active = carrier_sync_ff[1];
   assign phy_collision_active = phy_tx_active & phy_rx_active & ~full_duplex;
   assign half_duplex_loopback_off = hdl_off_ff;
   assign receive_normal_mode = rx_normal_ff;

   assign link_evt = live_link_up ^ link_prev_ff;
   assign phy_link_irq = link_evt & phy_link_irq_en_ff & phy_global_irq_en_ff;
   assign phy_flag_rd = mgmt_rd & (mgmt_reg_address == `EPL_ADDR_IRQ_FLAG);
   assign flag_clr_wr = sfr_wr & (sfr_addr == `EPL_REG_FLAGS);

   // ****************************************
   // phy registers
   // ****************************************
   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         force_link_up_ff <= RST_CTL2[`EPL_C2_FORCE];
         hdl_off_ff <= RST_CTL2[`EPL_C2_HDL];
         rx_normal_ff <= RST_CTL2[`EPL_C2_RXN];
         led_ctrl_ff <= RST_LED_CTL[13:1];
         phy_link_irq_en_ff <= 1'b0;
         phy_global_irq_en_ff <= 1'b0;
         link_prev_ff <= 1'b0;
         phy_link_flag_ff <= 1'b0;
         phy_global_flag_ff <= 1'b0;
      end else begin
         link_prev_ff <= live_link_up;
         phy_link_flag_ff <= link_evt | (phy_link_flag_ff & ~phy_flag_rd);
         phy_global_flag_ff <= phy_link_irq | (phy_global_flag_ff & ~phy_flag_rd);
         if (mgmt_wr) begin
            case (mgmt_reg_address)
               `EPL_ADDR_CTL2: begin
                  force_link_up_ff <= mgmt_wr_data[`EPL_C2_FORCE];
                  hdl_off_ff <= mgmt_wr_data[`EPL_C2_HDL];
                  rx_normal_ff <= mgmt_wr_data[`EPL_C2_RXN];
               end
               `EPL_ADDR_LED_CTL: led_ctrl_ff <= mgmt_wr_data[13:1];
               `EPL_ADDR_IRQ_EN: begin
                  phy_link_irq_en_ff <= mgmt_wr_data[`EPL_IE_LINK];
                  phy_global_irq_en_ff <= mgmt_wr_data[`EPL_IE_GLOBAL];
               end
               default: force_link_up_ff <= force_link_up_ff;
            endcase
         end
      end
   end

   // ****************************************
   // management read path
   // ****************************************
   always @* begin
      nxt_rd_data = 16'h0000;
      case (mgmt_reg_address)
         `EPL_ADDR_CTL2: begin
            nxt_rd_data[`EPL_C2_FORCE] = force_link_up_ff;
            nxt_rd_data[`EPL_C2_HDL] = hdl_off_ff;
            nxt_rd_data[`EPL_C2_RXN] = rx_normal_ff;
         end
         `EPL_ADDR_STAT2: begin
            nxt_rd_data[`EPL_S2_TX] = phy_tx_active;
            nxt_rd_data[`EPL_S2_RX] = phy_rx_active;
            nxt_rd_data[`EPL_S2_COL] = phy_collision_active;
            nxt_rd_data[`EPL_S2_LINK] = live_link_up;
         end
         `EPL_ADDR_IRQ_EN: begin
            nxt_rd_data[`EPL_IE_LINK] = phy_link_irq_en_ff;
            nxt_rd_data[`EPL_IE_GLOBAL] = phy_global_irq_en_ff;
         end
         `EPL_ADDR_IRQ_FLAG: begin
            nxt_rd_data[`EPL_IR_LINK] = phy_link_flag_ff;
            nxt_rd_data[`EPL_IR_GLOBAL] = phy_global_flag_ff;
         end
         `EPL_ADDR_LED_CTL: nxt_rd_data[13:1] = led_ctrl_ff;
         // unmapped addresses read zero
         default: nxt_rd_data = 16'h0000;
      endcase
   end

   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         mgmt_rd_data_ff <= 16'h0000;
         mgmt_rd_valid_ff <= 1'b0;
      end else begin
         mgmt_rd_valid_ff <= mgmt_rd;
         if (mgmt_rd) begin
            mgmt_rd_data_ff <= nxt_rd_data;
         end
      end
   end

   // ****************************************
   // module interrupt flags and enables
   // ****************************************
   assign flag_val = {1'b0, packet_pending, copy_done_flag_ff, link_change_flag_ff,
                      tx_done_flag_ff, 1'b0, tx_err_flag_ff, rx_err_flag_ff};

   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         eth_irq_en_ff <= `EPL_RST_ENABLE;
         copy_done_flag_ff <= 1'b0;
         tx_done_flag_ff <= 1'b0;
         tx_err_flag_ff <= 1'b0;
         rx_err_flag_ff <= 1'b0;
         link_change_flag_ff <= 1'b0;
         eth_master_irq_flag_ff <= 1'b0;
         sfr_rd_data_ff <= 8'h00;
      end else begin
         if (sfr_wr && (sfr_addr == `EPL_REG_ENABLE)) begin
            eth_irq_en_ff <= sfr_wr_data & `EPL_ENABLE_MASK;
         end
         copy_done_flag_ff <= copy_done_event | (copy_done_flag_ff & ~(flag_clr_wr & sfr_wr_data[`EPL_E_DMA]));
         tx_done_flag_ff <= transmit_done_event | (tx_done_flag_ff & ~(flag_clr_wr & sfr_wr_data[`EPL_E_TX]));
         tx_err_flag_ff <= transmit_error_event | (tx_err_flag_ff & ~(flag_clr_wr & sfr_wr_data[`EPL_E_TXER]));
         rx_err_flag_ff <= receive_error_event | (rx_err_flag_ff & ~(flag_clr_wr & sfr_wr_data[`EPL_E_RXER]));
         // set by phy, cleared by phy flag read
         link_change_flag_ff <= phy_link_irq | (link_change_flag_ff & ~phy_flag_rd);
         // master flag needs enable and global enable
         eth_master_irq_flag_ff <= ((|(flag_val & eth_irq_en_ff)) & eth_global_irq_enable) |
                                   (eth_master_irq_flag_ff & ~eth_master_irq_clear);
         sfr_rd_data_ff <= (sfr_addr == `EPL_REG_ENABLE) ? eth_irq_en_ff : flag_val;
      end
   end

   // ****************************************
   // millisecond tick and blink
   // ****************************************
   // one shared divider keeps both leds in phase
   assign ms_tick = (tick_cnt_ff == TICK_LAST);

   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         tick_cnt_ff <= 20'h0_0000;
         fast_cnt_ff <= {CNT_W{1'b0}};
         slow_cnt_ff <= {CNT_W{1'b0}};
         blink_fast_ff <= 1'b0;
         blink_slow_ff <= 1'b0;
      end else begin
         tick_cnt_ff <= ms_tick ? 20'h0_0000 : tick_cnt_ff + 20'h0_0001;
         if (ms_tick) begin
            fast_cnt_ff <= ms_step(fast_cnt_ff, FAST_LAST);
            slow_cnt_ff <= ms_step(slow_cnt_ff, SLOW_LAST);
            if (fast_cnt_ff == FAST_LAST) begin
               blink_fast_ff <= ~blink_fast_ff;
            end
            if (slow_cnt_ff == SLOW_LAST) begin
               blink_slow_ff <= ~blink_slow_ff;
            end
         end
      end
   end

   // ****************************************
   // stretch selection
   // ****************************************
   always @* begin
      case (led_ctrl_ff[`EPL_LC_FRQ_HI:`EPL_LC_FRQ_LO])
         2'h1: hold_len = MEDIUM_LEN;
         2'h2: hold_len = LONG_LEN;
         // reserved 11 falls back to normal
         default: hold_len = NORMAL_LEN;
      endcase
   end

   epl_stretch #(.CNT_W(CNT_W)) u_str_tx (
      .ref_clk(ref_clk), .reset(reset), .ms_tick(ms_tick), .hold_ms(hold_len), .event_now(phy_tx_active),
      .event_long(tx_long));

   epl_stretch #(.CNT_W(CNT_W)) u_str_rx (
      .ref_clk(ref_clk), .reset(reset), .ms_tick(ms_tick), .hold_ms(hold_len), .event_now(phy_rx_active),
      .event_long(rx_long));

   epl_stretch #(.CNT_W(CNT_W)) u_str_col (
      .ref_clk(ref_clk), .reset(reset), .ms_tick(ms_tick), .hold_ms(hold_len), .event_now(phy_collision_active),
      .event_long(col_long));

   // ****************************************
   // led drivers
   // ****************************************
   // first led field
   epl_led_sel u_led_a (
      .ref_clk(ref_clk), .reset(reset), .func_sel(led_ctrl_ff[`EPL_LC_A_HI:`EPL_LC_A_LO]),
      .stretch_en(led_ctrl_ff[`EPL_LC_STRETCH_EN]), .tx_now(phy_tx_active), .rx_now(phy_rx_active),
      .col_now(phy_collision_active), .tx_long(tx_long), .rx_long(rx_long), .col_long(col_long),
      .link_up(live_link_up), .duplex_full(full_duplex), .blink_fast(blink_fast_ff), .blink_slow(blink_slow_ff),
      .led_on_ff(led_a_on)
   );

   epl_led_sel u_led_b (
      .ref_clk(ref_clk), .reset(reset), .func_sel(led_ctrl_ff[`EPL_LC_B_HI:`EPL_LC_B_LO]),
      .stretch_en(led_ctrl_ff[`EPL_LC_STRETCH_EN]), .tx_now(phy_tx_active), .rx_now(phy_rx_active),
      .col_now(phy_collision_active), .tx_long(tx_long), .rx_long(rx_long), .col_long(col_long),
      .link_up(live_link_up), .duplex_full(full_duplex), .blink_fast(blink_fast_ff), .blink_slow(blink_slow_ff),
      .led_on_ff(led_b_on)
   );

endmodule // epl_core

// ==== design/epl_led_sel.v ====
`timescale 1ns/1ps
`include "epl_consts.vh"

module epl_led_sel (
   // clock and reset
   input wire ref_clk,
   input wire reset,
   // configuration
   input wire [3:0] func_sel,
   input wire stretch_en,
   // live activity
   input wire tx_now,
   input wire rx_now,
   input wire col_now,
   // stretched activity
   input wire tx_long,
   input wire rx_long,
   input wire col_long,
   // steady state
   input wire link_up,
   input wire duplex_full,
   input wire blink_fast,
   input wire blink_slow,
   // led drive
   output reg led_on_ff
);

   reg nxt_led_on;
   wire tx_v;
   wire rx_v;
   wire col_v;

   assign tx_v = stretch_en ? tx_long : tx_now;
   assign rx_v = stretch_en ? rx_long : rx_now;
   assign col_v = stretch_en ? col_long : col_now;

   // ****************************************
   // function decode
   // ****************************************
   always @* begin
      case (func_sel)
         `EPL_LED_TX: nxt_led_on = tx_v;
         `EPL_LED_RX: nxt_led_on = rx_v;
         `EPL_LED_COL: nxt_led_on = col_v;
         `EPL_LED_LINK: nxt_led_on = link_up;
         `EPL_LED_DPX: nxt_led_on = duplex_full;
         `EPL_LED_TXRX: nxt_led_on = tx_v | rx_v;
         `EPL_LED_ON: nxt_led_on = 1'b1;
         `EPL_LED_OFF: nxt_led_on = 1'b0;
         `EPL_LED_FAST: nxt_led_on = blink_fast;
         `EPL_LED_SLOW: nxt_led_on = blink_slow;
         `EPL_LED_LNK_RX: nxt_led_on = link_up & ~rx_long;
         `EPL_LED_LNK_TXRX: nxt_led_on = link_up & ~(tx_long | rx_long);
         // reserved codes keep the led dark
         default: nxt_led_on = 1'b0;
      endcase
   end

   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         led_on_ff <= 1'b0;
      end else begin
         led_on_ff <= nxt_led_on;
      end
   end

endmodule // epl_led_sel

// ==== design/epl_stretch.v ====
`timescale 1ns/1ps
`include "epl_consts.vh"

module epl_stretch #(
   parameter CNT_W = 9
) (
   // clock and reset
   input wire ref_clk,
   input wire reset,
   // timing
   input wire ms_tick,
   input wire [CNT_W-1:0] hold_ms,
   // event in, stretched out
   input wire event_now,
   output wire event_long
);

   reg [CNT_W-1:0] left_ff;
   reg [CNT_W-1:0] nxt_left;

   // ****************************************
   // retriggerable hold counter
   // ****************************************
   // hold restarts while the event lasts, so bursts merge
   always @* begin
      nxt_left = left_ff;
      if (event_now) begin
         nxt_left = hold_ms;
      end else if (ms_tick && (left_ff != {CNT_W{1'b0}})) begin
         nxt_left = left_ff - {{(CNT_W-1){1'b0}}, 1'b1};
      end
   end

   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         left_ff <= {CNT_W{1'b0}};
      end else begin
         left_ff <= nxt_left;
      end
   end

   assign event_long = event_now | (left_ff != {CNT_W{1'b0}});

endmodule // epl_stretch

// ==== inc/epl_consts.vh ====
`ifndef EPL_CONSTS_VH
`define EPL_CONSTS_VH

// ****************************************
// phy register addresses (management port)
// ****************************************
`define EPL_ADDR_CTL2 5'h10
`define EPL_ADDR_STAT2 5'h11
`define EPL_ADDR_IRQ_EN 5'h12
`define EPL_ADDR_IRQ_FLAG 5'h13
`define EPL_ADDR_LED_CTL 5'h14

// ****************************************
// controller-side register index
// ****************************************
`define EPL_REG_ENABLE 1'h0
`define EPL_REG_FLAGS 1'h1

// ****************************************
// field positions
// ****************************************
`define EPL_C2_FORCE 14
`define EPL_C2_HDL 8
`define EPL_C2_RXN 4
`define EPL_S2_TX 13
`define EPL_S2_RX 12
`define EPL_S2_COL 11
`define EPL_S2_LINK 10
`define EPL_LC_KEEP_HI 13
`define EPL_LC_KEEP_LO 12
`define EPL_LC_A_HI 11
`define EPL_LC_A_LO 8
`define EPL_LC_B_HI 7
`define EPL_LC_B_LO 4
`define EPL_LC_FRQ_HI 3
`define EPL_LC_FRQ_LO 2
`define EPL_LC_STRETCH_EN 1
`define EPL_IE_LINK 4
`define EPL_IE_GLOBAL 1
`define EPL_IR_LINK 4
`define EPL_IR_GLOBAL 2
`define EPL_E_PKT 6
`define EPL_E_DMA 5
`define EPL_E_LINK 4
`define EPL_E_TX 3
`define EPL_E_TXER 1
`define EPL_E_RXER 0
`define EPL_ENABLE_MASK 8'h7b

// ****************************************
// reset values
// ****************************************
`define EPL_RST_CTL2 16'h0000
`define EPL_RST_LED_CTL 16'h3422
`define EPL_RST_ENABLE 8'h00

// ****************************************
// led codes
// ****************************************
`define EPL_LED_TX 4'h1
`define EPL_LED_RX 4'h2
`define EPL_LED_COL 4'h3
`define EPL_LED_LINK 4'h4
`define EPL_LED_DPX 4'h5
`define EPL_LED_TXRX 4'h7
`define EPL_LED_ON 4'h8
`define EPL_LED_OFF 4'h9
`define EPL_LED_FAST 4'ha
`define EPL_LED_SLOW 4'hb
`define EPL_LED_LNK_RX 4'hc
`define EPL_LED_LNK_TXRX 4'hd

// ****************************************
// timing
// ****************************************
`define EPL_CLK_KHZ 25000
`define EPL_TICK_MS 1
`define EPL_NORMAL_MS 32
`define EPL_MEDIUM_MS 64
`define EPL_LONG_MS 128
`define EPL_FAST_MS 64
`define EPL_SLOW_MS 256

`endif
